//--- rtl/bmg_core.sv
// Backup mode bus gating: picks the switchover criterion and decides
// what stays usable while the part runs from battery.
// Assumes comparator levels and requests are synchronous to sys_clk_i;
// the two selection bits come from the configuration store.
`timescale 1ns/1ps
module bmg_core #(
   parameter int CNT_W = bmg_pkg::BMG_CNT_W,
   parameter int HOLD_CYC = bmg_pkg::BMG_FILTER_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Selection bits and their load strobe
   input wire logic backup_bus_inhibit_i,
   input wire logic supply_switch_select_i,
   input wire logic cfg_load_i,
   // Supply comparators: main below trip_threshold, main below battery
   input wire logic main_below_trip_i,
   input wire logic main_below_bat_i,
   // Requests from the serial slave and the alarm/clock logic
   input wire logic nvm_req_i,
   input wire logic irq_assert_i,
   // Status and gating outputs
   output logic on_battery_o,
   output logic [1:0] backup_mode_o,
   output logic serial_enable_o,
   output logic nvm_grant_o,
   output logic nvm_refused_o,
   // Open-drain interrupt_freq_output, enable high while pulling low
   output logic interrupt_freq_output_o,
   output logic interrupt_freq_output_oe_o
);

   // Settings the filters cannot serve are refused before the run
   initial begin
      if (CNT_W < 1) begin
         $error("bmg_core: CNT_W must be at least 1");
      end
      if (HOLD_CYC < 1) begin
         $error("bmg_core: HOLD_CYC must be at least 1");
      end
      if (HOLD_CYC >= (1 << CNT_W)) begin
         $error("bmg_core: HOLD_CYC does not fit CNT_W");
      end
   end

   // Selection bits
   logic inhibit_q;
   logic inhibit_d;
   logic switch_sel_q;
   logic switch_sel_d;

   // Filtered comparators and the selected criterion
   logic trip_f;
   logic bat_f;
   logic criterion;
   bmg_pkg::bmg_mode_e mode;

   // Power state
   bmg_pkg::bmg_state_e state_q;
   bmg_pkg::bmg_state_e state_d;
   logic on_batt_q;
   logic on_batt_d;

   // Gating results
   logic serial_en_q;
   logic serial_en_d;
   logic grant_q;
   logic grant_d;
   logic refused_q;
   logic refused_d;

   // Open-drain pin
   logic irq_oe_q;
   logic irq_oe_d;
   logic irq_data_q;
   logic irq_data_d;

   // Both comparators are filtered so a glitch cannot flip the supply
   bmg_filter #(.CNT_W(CNT_W), .HOLD_CYC(HOLD_CYC)) u_trip (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .level_i(main_below_trip_i),
      .level_o(trip_f)
   );

   bmg_filter #(.CNT_W(CNT_W), .HOLD_CYC(HOLD_CYC)) u_bat (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .level_i(main_below_bat_i),
      .level_o(bat_f)
   );

   // Selection bits are held so a stray level cannot change the mode
   always_comb begin
      inhibit_d = inhibit_q;
      switch_sel_d = switch_sel_q;
      if (cfg_load_i) begin
         inhibit_d = backup_bus_inhibit_i;
         switch_sel_d = supply_switch_select_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         inhibit_q <= bmg_pkg::BMG_INHIBIT_RST;
         switch_sel_q <= bmg_pkg::SWITCH_SEL_RST;
      end else begin
         inhibit_q <= inhibit_d;
         switch_sel_q <= switch_sel_d;
      end
   end

   // Mode decode and switchover criterion
   always_comb begin
      mode = bmg_pkg::bmg_mode_e'({inhibit_q, switch_sel_q});
      case (mode)
         // Lower of trip and battery: below both comparators
         bmg_pkg::BMG_MODE_A: criterion = trip_f & bat_f;
         bmg_pkg::BMG_MODE_B: criterion = bat_f;
         bmg_pkg::BMG_MODE_C: criterion = trip_f & bat_f;
         bmg_pkg::BMG_MODE_D: criterion = bat_f;
         default: criterion = bat_f;
      endcase
   end

   // Power state
   always_comb begin
      state_d = state_q;
      case (state_q)
         bmg_pkg::BMG_ST_MAIN: begin
            if (criterion) begin
               state_d = bmg_pkg::BMG_ST_BACKUP;
            end
         end
         bmg_pkg::BMG_ST_BACKUP: begin
            if (!criterion) begin
               state_d = bmg_pkg::BMG_ST_MAIN;
            end
         end
         default: begin
            state_d = bmg_pkg::BMG_ST_MAIN;
         end
      endcase
      on_batt_d = (state_d == bmg_pkg::BMG_ST_BACKUP);
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state_q <= bmg_pkg::BMG_ST_MAIN;
         on_batt_q <= 1'b0;
      end else begin
         state_q <= state_d;
         on_batt_q <= on_batt_d;
      end
   end

   // Gating follows the next state so it moves with on_battery_o
   always_comb begin
      // Bus off only in backup with inhibit set; host sees no ack then
      serial_en_d = !(on_batt_d && inhibit_q);
      grant_d = nvm_req_i && !on_batt_d;
      refused_d = nvm_req_i && on_batt_d;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         serial_en_q <= 1'b1;
         grant_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         serial_en_q <= serial_en_d;
         grant_q <= grant_d;
         refused_q <= refused_d;
      end
   end

   // Not gated by supply state so alarms reach the pin on battery
   always_comb begin
      irq_oe_d = irq_assert_i;
      // Open drain: the data side only ever pulls low
      irq_data_d = 1'b0;
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_oe_q <= 1'b0;
         irq_data_q <= 1'b0;
      end else begin
         irq_oe_q <= irq_oe_d;
         irq_data_q <= irq_data_d;
      end
   end

   // Every output is a flip-flop, so nothing glitches at the pins
   assign on_battery_o = on_batt_q;
   assign backup_mode_o = {inhibit_q, switch_sel_q};
   assign serial_enable_o = serial_en_q;
   assign nvm_grant_o = grant_q;
   assign nvm_refused_o = refused_q;
   assign interrupt_freq_output_o = irq_data_q;
   assign interrupt_freq_output_oe_o = irq_oe_q;

endmodule

//--- shared/bmg_pkg.sv
// Constants and types for the backup mode bus gating block.
// Assumes a single 50 MHz system clock and synchronous active-high reset.
package bmg_pkg;

   // Backup modes decoded from {backup_bus_inhibit, supply_switch_select}
   typedef enum logic [1:0] {
      BMG_MODE_A,
      BMG_MODE_B,
      BMG_MODE_C,
      BMG_MODE_D
   } bmg_mode_e;

   // Power state machine
   typedef enum logic [1:0] {
      BMG_ST_MAIN,
      BMG_ST_BACKUP
   } bmg_state_e;

   // Reset values of the two selection bits
   localparam logic BMG_INHIBIT_RST = 1'b0;
   localparam logic SWITCH_SEL_RST = 1'b0;

   // Comparator filtering: the supply decision must hold this long
   localparam int BMG_CLK_MHZ = 50;
   localparam int BMG_FILTER_NS = 100;
   localparam int BMG_FILTER_CYC =
      (BMG_FILTER_NS * BMG_CLK_MHZ + 999) / 1000;

   // Width of the filter counter
   localparam int BMG_CNT_W = 4;

endpackage

//--- rtl/bmg_filter.sv
// Persistence filter for one supply comparator level.
// Assumes the input is already synchronous to sys_clk_i.
`timescale 1ns/1ps
module bmg_filter #(
   parameter int CNT_W = 4,
   parameter int HOLD_CYC = 5
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Level in and filtered level out
   input wire logic level_i,
   output logic level_o
);

   initial begin
      if (HOLD_CYC < 1 || HOLD_CYC >= (1 << CNT_W)) begin
         $error("bmg_filter: HOLD_CYC does not fit CNT_W");
      end
   end

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic level_q, level_d;

   always_comb begin
      cnt_d = cnt_q;
      level_d = level_q;
      if (level_i == level_q) begin
         cnt_d = '0;
      end else if (cnt_q == CNT_W'(HOLD_CYC - 1)) begin
         cnt_d = '0;
         level_d = level_i;
      end else begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cnt_q <= '0;
         level_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         level_q <= level_d;
      end
   end

   assign level_o = level_q;

endmodule

//--- sim/bmg_host_model.sv
// Host controller model on the far side of the gated serial bus.
// Assumes requests are issued on sys_clk_i edges.
`timescale 1ns/1ps
module bmg_host_model (
   // Clock and request strobe from the bench, bus enable from the core
   input wire logic sys_clk_i,
   input wire logic go_i,
   input wire logic serial_enable_i,
   // Memory request and silent bus indication
   output logic nvm_req_o,
   output logic nak_ok_o
);
   always_ff @(posedge sys_clk_i) begin
      nvm_req_o <= go_i;
   end
   // Silence while the bus is off is normal, not a fault
   assign nak_ok_o = go_i & ~serial_enable_i;
endmodule

//--- sim/bmg_sva.sv
// Checker for the backup mode gating outputs.
// Assumes it is bound to bmg_core and sees only its ports.
`timescale 1ns/1ps
module bmg_sva (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic backup_bus_inhibit_i,
   input wire logic supply_switch_select_i,
   input wire logic cfg_load_i,
   input wire logic main_below_trip_i,
   input wire logic main_below_bat_i,
   input wire logic irq_assert_i,
   input wire logic on_battery_o,
   input wire logic [1:0] backup_mode_o,
   input wire logic serial_enable_o,
   input wire logic nvm_grant_o,
   input wire logic nvm_refused_o,
   input wire logic interrupt_freq_output_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   a_mode_decode: assert property (cfg_load_i |=> backup_mode_o ==
      $past({backup_bus_inhibit_i, supply_switch_select_i}))
      else $error("mode not decoded");
   a_nvm_refuse: assert property (nvm_refused_o |->
      on_battery_o && !nvm_grant_o) else $error("bad refusal");
   a_std_enter: assert property ($rose(on_battery_o) && !backup_mode_o[0]
      |-> $past(main_below_trip_i && main_below_bat_i))
      else $error("standard switchover wrong");
   a_leg_enter: assert property ($rose(on_battery_o) && backup_mode_o[0]
      |-> $past(main_below_bat_i)) else $error("legacy wrong");
   a_bus_kept: assert property (on_battery_o && !backup_mode_o[1]
      |-> serial_enable_o) else $error("bus dropped");
   a_bus_off: assert property (on_battery_o && backup_mode_o[1]
      |-> !serial_enable_o) else $error("bus not off");
   a_irq_live: assert property (irq_assert_i |=>
      interrupt_freq_output_oe_o) else $error("pin idle");
   c_backup: cover property ($rose(on_battery_o));
   c_bus_off: cover property (on_battery_o && !serial_enable_o);
   c_refused: cover property (nvm_refused_o);
endmodule
bind bmg_core bmg_sva i_sva (.*);

//--- sim/tb.sv
// Self-checking bench for the backup mode gating block.
// Assumes the host model supplies memory requests.
`timescale 1ns/1ps
module tb;
   logic sys_clk_i = 0, srst_i = 1, inh = 0, sel = 0, ld = 0;
   logic trip = 0, bat = 0, go = 0, irq = 0, req, nak;
   logic on_b, se, gr, rf, fo, oe;
   logic [1:0] md;
   int error_cnt = 0, checked = 0, cyc = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   bmg_host_model i_host (.sys_clk_i(sys_clk_i), .go_i(go),
      .serial_enable_i(se), .nvm_req_o(req), .nak_ok_o(nak));
   bmg_core i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .backup_bus_inhibit_i(inh), .supply_switch_select_i(sel),
      .cfg_load_i(ld), .main_below_trip_i(trip), .main_below_bat_i(bat),
      .nvm_req_i(req), .irq_assert_i(irq), .on_battery_o(on_b),
      .backup_mode_o(md), .serial_enable_o(se), .nvm_grant_o(gr),
      .nvm_refused_o(rf), .interrupt_freq_output_o(fo),
      .interrupt_freq_output_oe_o(oe));
   task stop_test;
      if (error_cnt == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [3:0] g, input logic [3:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %0t got %b want %b", $time, g, e);
      end
   endtask
   // Wrong comparator alone first, then the full criterion
   task run_mode(input logic [1:0] m);
      @(posedge sys_clk_i) {inh, sel} <= m;
      ld <= 1;
      @(posedge sys_clk_i) ld <= 0;
      trip <= m[0];
      bat <= !m[0];
      go <= 1;
      repeat (9) @(posedge sys_clk_i);
      #1 chk(on_b, 0);
      chk(md, m);
      chk({gr, rf}, 4'h2);
      chk(nak, 0);
      @(posedge sys_clk_i) trip <= 1;
      bat <= 1;
      go <= 1;
      irq <= 1;
      repeat (9) @(posedge sys_clk_i);
      #1 chk(on_b, 1);
      chk(se, !m[1]);
      chk({gr, rf}, 2'h1);
      chk(oe, 1);
      chk(fo, 0);
      chk(nak, m[1]);
      @(posedge sys_clk_i) {trip, bat, go, irq} <= 4'h0;
      repeat (9) @(posedge sys_clk_i);
      #1 chk({on_b, se, oe}, 3'h2);
   endtask
   // Reset while on battery in mode D, then standard entry in mode A
   task reset_mid;
      @(posedge sys_clk_i) {inh, sel} <= 2'h3;
      ld <= 1;
      trip <= 1;
      bat <= 1;
      @(posedge sys_clk_i) ld <= 0;
      repeat (8) @(posedge sys_clk_i);
      #1 chk({on_b, se}, 2'h2);
      @(posedge sys_clk_i) srst_i <= 1;
      @(posedge sys_clk_i) srst_i <= 0;
      #1 chk({on_b, se, md}, 4'h4);
      repeat (6) @(posedge sys_clk_i);
      #1 chk({on_b, se, md}, 4'hc);
      @(posedge sys_clk_i) {trip, bat} <= 2'h0;
      repeat (9) @(posedge sys_clk_i);
      #1 chk(on_b, 0);
   endtask
   always @(posedge sys_clk_i)
      if (++cyc > 3000) begin
         error_cnt++;
         stop_test;
      end
   initial begin
      repeat (12) @(posedge sys_clk_i);
      srst_i <= 0;
      #1 chk({se, md}, 3'h4);
      for (int m = 0; m < 4; m++)
         run_mode(m[1:0]);
      reset_mid;
      stop_test;
   end
endmodule
